// ==== rtl/fmid_regs.vh ====
`ifndef FMID_REGS_VH
`define FMID_REGS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FMID_OP_ADDC 8'h30
`define FMID_OP_CADD 8'h10
`define FMID_OP_COMP 8'h40
`define FMID_OP_XOR 8'h02
`define FMID_OP_IJMP 8'hff
`define FMID_OP_RET 8'h48
`define FMID_OP_RETURN_THEN_SKIP 8'h49
`define FMID_OP_SKC 8'h20
`define FMID_OP_SKE 8'h21
`define FMID_OP_SKT 8'h41
`define FMID_OP_SWAP 8'h4f
`define FMID_OP_PFX 8'h33
`define FMID_OP_BZ0 8'h01
`define FMID_OP_BZ1 8'h11
`define FMID_OP_BZ2 8'h03
`define FMID_OP_BZ3 8'h13
`define FMID_OP_READ_GENERAL_INPUTS 8'h28
`define FMID_OP_READ_INPUT_LATCHES 8'h29
`define FMID_OP_OBD 8'h3e
`define FMID_OP_OMG 8'h3a
`define FMID_HI_ADD_IMMEDIATE_SKIP 4'h5
`define FMID_HI_LBI 4'h0
`define FMID_HI_LEI 4'h6
`define FMID_LEI_SEL 4'h3
`define FMID_HI_LONG 4'h6
`define FMID_SUB_PAGE 4'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FMID_RST_PC 10'h000
`define FMID_RST_NIB 4'h0
`endif

// ==== rtl/fmid_core.v ====
`timescale 1ns/10ps
`include "fmid_regs.vh"
// Notes on behaviour
// - 30 adds A, carry, RAM; skip carry
// - Add immediate to A, skip on carry
// - 10 adds not-A, RAM, carry; skip
// - 40 complements A, never skips
// - 02 XORs RAM into A
// - FF loads PC low from ROM
// - In-page jump keeps page bits
// - Page call pushes, forces page 0010
// - 48/49 pop stack; 49 always skips
// - 21 skip if A equals RAM; 20 carry
// - 33 21 skips if port zero
// - 33 then bit code tests port bit
// - Single bit codes test RAM bit
// - 41 skips on timebase carry latch
// - 33 28 reads general inputs
// - 33 29 reads latches, clock pin
// - 33 3E copies pointer digit out
// - 33 5y writes port immediate
// - 33 3A writes RAM to port
// - 4F swaps shifter, carry to clock
// - Pointer load digit is code plus one
// - Enable load latches immediate
// - Skips take one cycle per byte
module fmid_core
(
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Program ROM
  input wire [7:0] rom_data,
  output reg [9:0] rom_addr,
  // Data RAM
  input wire [3:0] ram_data,
  output reg [5:0] ram_addr,
  // Pins and latches
  input wire [3:0] gen_inputs,
  input wire clock_out_pin,
  input wire [1:0] falling_pulse_latches,
  input wire timebase_carry,
  input wire [3:0] shift_count_in,
  // Outputs
  output reg [3:0] acc_out,
  output reg carry_out,
  output reg [3:0] port_latch,
  output reg [3:0] data_port,
  output reg [3:0] enable_reg,
  output reg [3:0] shift_count_out,
  output reg shift_count_load,
  output reg serial_clock_output,
  output reg latch_clear
);
  localparam S_FETCH = 2'd0;
  localparam S_SECOND = 2'd1;
  localparam S_IND = 2'd2;
  localparam K_NONE = 2'd0;
  localparam K_PFX = 2'd1;
  localparam K_LONG = 2'd2;
  localparam K_LBI = 2'd3;
  reg [1:0] state_reg;
  reg [1:0] kind_reg;
  reg [9:0] pc_reg;
  reg [9:0] sa_reg;
  reg [9:0] sb_reg;
  reg [9:0] sc_reg;
  reg [3:0] a_reg;
  reg c_reg;
  reg skip_reg;
  reg [7:0] first_reg;
  reg tb_reg;
  reg [3:0] in_s1;
  reg [3:0] in_s2;
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg [9:0] pc_inc;
  reg [4:0] sum_asc;
  reg [4:0] sum_add_immediate_skip;
  reg [4:0] sum_complement_add_carry_skip;
  reg two_byte;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [4:0] add3;
    input [3:0] x;
    input [3:0] y;
    input ci;
    begin
      add3 = {1'b0, x} + {1'b0, y} + {4'h0, ci};
    end
  endfunction
  function bitsel;
    input [3:0] v;
    input [7:0] op;
    begin
      bitsel = v[{op[1], op[4]}];
    end
  endfunction
  function isbit;
    input [7:0] op;
    begin
      isbit = (op == `FMID_OP_BZ0) || (op == `FMID_OP_BZ1) ||
              (op == `FMID_OP_BZ2) || (op == `FMID_OP_BZ3);
    end
  endfunction
  function [9:0] incr;
    input [9:0] p;
    begin
      incr = p + 10'h001;
    end
  endfunction
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge clock)
  begin
    in_s1 <= gen_inputs;
    in_s2 <= in_s1;
    pin_s1 <= {falling_pulse_latches[1], clock_out_pin, falling_pulse_latches[0]};
    pin_s2 <= pin_s1;
  end
  // ----------------------------------------
  // Decode and execute
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= S_FETCH;
      kind_reg <= K_NONE;
      pc_reg <= `FMID_RST_PC;
      rom_addr <= `FMID_RST_PC;
      sa_reg <= `FMID_RST_PC;
      sb_reg <= `FMID_RST_PC;
      sc_reg <= `FMID_RST_PC;
      a_reg <= `FMID_RST_NIB;
      c_reg <= 1'b0;
      skip_reg <= 1'b0;
      first_reg <= 8'h00;
      tb_reg <= 1'b0;
      ram_addr <= 6'h00;
      port_latch <= `FMID_RST_NIB;
      data_port <= `FMID_RST_NIB;
      enable_reg <= `FMID_RST_NIB;
      shift_count_out <= `FMID_RST_NIB;
      shift_count_load <= 1'b0;
      serial_clock_output <= 1'b0;
      latch_clear <= 1'b0;
    end
    else
    begin
      shift_count_load <= 1'b0;
      latch_clear <= 1'b0;
      if (timebase_carry)
        tb_reg <= 1'b1;
      pc_reg <= pc_inc;
      rom_addr <= pc_inc;
      case (state_reg)
        S_FETCH:
        begin
          first_reg <= rom_data;
          if (skip_reg)
          begin
            // One cycle per skipped byte; second bytes skipped too
            if (two_byte)
            begin
              state_reg <= S_SECOND;
              kind_reg <= K_NONE;
            end
            else
              skip_reg <= 1'b0;
          end
          else if (rom_data == `FMID_OP_PFX)
          begin
            state_reg <= S_SECOND;
            kind_reg <= K_PFX;
          end
          else if (rom_data[7:4] == `FMID_HI_LONG && !rom_data[2])
          begin
            state_reg <= S_SECOND;
            kind_reg <= K_LONG;
          end
          else if (two_byte)
          begin
            state_reg <= S_SECOND;
            kind_reg <= K_LBI;
          end
          else if (rom_data == `FMID_OP_ADDC)
          begin
            a_reg <= sum_asc[3:0];
            c_reg <= sum_asc[4];
            skip_reg <= sum_asc[4];
          end
          else if (rom_data[7:4] == `FMID_HI_ADD_IMMEDIATE_SKIP && rom_data[3:0] != 4'h0)
          begin
            a_reg <= sum_add_immediate_skip[3:0];
            skip_reg <= sum_add_immediate_skip[4];
          end
          else if (rom_data == `FMID_OP_CADD)
          begin
            a_reg <= sum_complement_add_carry_skip[3:0];
            c_reg <= sum_complement_add_carry_skip[4];
            skip_reg <= sum_complement_add_carry_skip[4];
          end
          else if (rom_data == `FMID_OP_COMP)
            a_reg <= ~a_reg;
          else if (rom_data == `FMID_OP_XOR)
            a_reg <= a_reg ^ ram_data;
          else if (rom_data == `FMID_OP_IJMP)
          begin
            rom_addr <= {pc_inc[9:8], a_reg, ram_data};
            state_reg <= S_IND;
          end
          else if (rom_data[7] && (rom_data[6] || pc_inc[9:7] == 3'b001))
          begin
            if (pc_inc[9:7] == 3'b001)
              pc_reg <= {pc_inc[9:7], rom_data[6:0]};
            else
              pc_reg <= {pc_inc[9:6], rom_data[5:0]};
            rom_addr <= (pc_inc[9:7] == 3'b001) ? {pc_inc[9:7], rom_data[6:0]} :
                        {pc_inc[9:6], rom_data[5:0]};
          end
          else if (rom_data[7:6] == 2'b10)
          begin
            sc_reg <= sb_reg;
            sb_reg <= sa_reg;
            sa_reg <= pc_inc;
            pc_reg <= {`FMID_SUB_PAGE, rom_data[5:0]};
            rom_addr <= {`FMID_SUB_PAGE, rom_data[5:0]};
          end
          else if (rom_data == `FMID_OP_RET || rom_data == `FMID_OP_RETURN_THEN_SKIP)
          begin
            pc_reg <= sa_reg;
            rom_addr <= sa_reg;
            sa_reg <= sb_reg;
            sb_reg <= sc_reg;
            skip_reg <= rom_data[0];
          end
          else if (rom_data == `FMID_OP_SKC)
            skip_reg <= c_reg;
          else if (rom_data == `FMID_OP_SKE)
            skip_reg <= (a_reg == ram_data);
          else if (isbit(rom_data))
            skip_reg <= !bitsel(ram_data, rom_data);
          else if (rom_data == `FMID_OP_SKT)
          begin
            skip_reg <= tb_reg;
            tb_reg <= timebase_carry;
          end
          else if (rom_data == `FMID_OP_SWAP)
          begin
            a_reg <= shift_count_in;
            shift_count_out <= a_reg;
            shift_count_load <= 1'b1;
            serial_clock_output <= c_reg;
          end
          else if (rom_data[7:6] == 2'b00 && rom_data[3:0] >= 4'h8)
            ram_addr <= {rom_data[5:4], rom_data[3:0] + 4'h1};
        end
        S_SECOND:
        begin
          state_reg <= S_FETCH;
          if (skip_reg)
            skip_reg <= 1'b0;
          else if (kind_reg == K_LONG)
          begin
            if (first_reg[3])
            begin
              sc_reg <= sb_reg;
              sb_reg <= sa_reg;
              sa_reg <= pc_inc;
            end
            pc_reg <= {first_reg[1:0], rom_data};
            rom_addr <= {first_reg[1:0], rom_data};
          end
          else if (kind_reg == K_LBI)
            ram_addr <= {first_reg[5:4], rom_data[3:0]};
          else if (kind_reg == K_PFX)
          begin
            if (rom_data == `FMID_OP_SKE)
              skip_reg <= (port_latch == 4'h0);
            else if (isbit(rom_data))
              skip_reg <= !bitsel(port_latch, rom_data);
            else if (rom_data == `FMID_OP_READ_GENERAL_INPUTS)
              a_reg <= in_s2;
            else if (rom_data == `FMID_OP_READ_INPUT_LATCHES)
            begin
              a_reg <= {pin_s2[2], pin_s2[1], 1'b0, pin_s2[0]};
              latch_clear <= 1'b1;
            end
            else if (rom_data == `FMID_OP_OBD)
              data_port <= ram_addr[3:0];
            else if (rom_data[7:4] == `FMID_HI_ADD_IMMEDIATE_SKIP)
              port_latch <= rom_data[3:0];
            else if (rom_data == `FMID_OP_OMG)
              port_latch <= ram_data;
            else if (rom_data[7:4] == `FMID_HI_LEI)
              enable_reg <= rom_data[3:0];
          end
        end
        S_IND:
        begin
          state_reg <= S_FETCH;
          pc_reg <= {pc_reg[9:8], rom_data};
          rom_addr <= {pc_reg[9:8], rom_data};
        end
        default:
          state_reg <= S_FETCH;
      endcase
    end
  end
  always @*
  begin
    pc_inc = incr(pc_reg);
    two_byte = (rom_data == `FMID_OP_PFX) || (rom_data[7:4] == `FMID_HI_LONG) ||
               (rom_data[7:4] == 4'h2 && rom_data[3:2] == 2'b11) ||
               (rom_data[7:4] == 4'h3 && rom_data[3:2] == 2'b11);
    sum_asc = add3(a_reg, ram_data, c_reg);
    sum_add_immediate_skip = add3(a_reg, rom_data[3:0], 1'b0);
    sum_complement_add_carry_skip = add3(~a_reg, ram_data, c_reg);
    acc_out = a_reg;
    carry_out = c_reg;
  end
endmodule // fmid_core

// ==== test/fmid_mem.sv ====
`timescale 1ns/10ps
module fmid_mem
(
  // Program store
  input wire [9:0] rom_addr,
  output wire [7:0] rom_data,
  // Data store
  input wire [5:0] ram_addr,
  output wire [3:0] ram_data
);
  logic [7:0] rom [0:1023];
  logic [3:0] ram [0:63];
  // Combinational reads
  assign rom_data = rom[rom_addr];
  assign ram_data = ram[ram_addr];
endmodule // fmid_mem

// ==== test/fmid_core_checker.sv ====
`timescale 1ns/10ps
module fmid_core_checker
(
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Watched ports
  input wire [7:0] rom_data,
  input wire [9:0] rom_addr,
  input wire [3:0] ram_data,
  input wire [5:0] ram_addr,
  input wire [3:0] acc_out,
  input wire carry_out,
  input wire [3:0] port_latch,
  input wire [3:0] data_port,
  input wire [3:0] enable_reg,
  input wire [3:0] shift_count_out,
  input wire shift_count_load,
  input wire serial_clock_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_pfx(ok); rom_data == 8'h33 ##1 ok; endsequence
  sequence s_jid; rom_data == 8'hff ##1 rom_addr[7:0] == {acc_out, ram_data}; endsequence
  property p_port; s_pfx(rom_data[7:4] == 4'h5) |=> port_latch == $past(rom_data[3:0]); endproperty
  property p_en; s_pfx(rom_data[7:4] == 4'h6) |=> enable_reg == $past(rom_data[3:0]); endproperty
  property p_obd; s_pfx(rom_data == 8'h3e) |=> data_port == $past(ram_addr[3:0]); endproperty
  property p_jid; s_jid |=> rom_addr[7:0] == $past(rom_data); endproperty
  property p_comp; rom_data == 8'h40 |=> acc_out == ~$past(acc_out); endproperty
  property p_xor; rom_data == 8'h02 |=> acc_out == ($past(acc_out) ^ $past(ram_data)); endproperty
  property p_swap;
    shift_count_load |-> shift_count_out == $past(acc_out) && serial_clock_output == $past(carry_out);
  endproperty
  property p_nop; rom_data == 8'h44 |=> rom_addr == $past(rom_addr) + 10'h001; endproperty
  a_port: assert property (p_port) else $error("port latch not loaded");
  a_en: assert property (p_en) else $error("enable register not loaded");
  a_obd: assert property (p_obd) else $error("data port not loaded");
  a_jid: assert property (p_jid) else $error("indirect jump wrong");
  a_comp: assert property (p_comp) else $error("complement wrong");
  a_xor: assert property (p_xor) else $error("exclusive or wrong");
  a_swap: assert property (p_swap) else $error("swap wrong");
  a_nop: assert property (p_nop) else $error("fetch did not advance");
endmodule // fmid_core_checker
bind fmid_core fmid_core_checker fmid_core_checker_inst (.clock(clock), .sys_rst(sys_rst),
  .rom_data(rom_data), .rom_addr(rom_addr), .ram_data(ram_data), .ram_addr(ram_addr),
  .acc_out(acc_out), .carry_out(carry_out), .port_latch(port_latch), .data_port(data_port),
  .enable_reg(enable_reg), .shift_count_out(shift_count_out),
  .shift_count_load(shift_count_load), .serial_clock_output(serial_clock_output));

// ==== test/tb.sv ====
`timescale 1ns/10ps
`define FMID_CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] gen_inputs = 4'h0;
  logic clock_out_pin = 1'b1;
  logic [1:0] falling_pulse_latches = 2'b11;
  logic timebase_carry = 1'b0;
  logic [3:0] shift_count_in = 4'h6;
  wire [7:0] rom_data;
  wire [9:0] rom_addr;
  wire [3:0] ram_data;
  wire [5:0] ram_addr;
  wire [3:0] acc_out, port_latch, data_port, enable_reg, shift_count_out;
  wire carry_out, shift_count_load, serial_clock_output, latch_clear;
  int failures = 0;
  int comparisons = 0;
  int clear_pulses = 0;
  always @(posedge clock)
    if (latch_clear === 1'b1)
      clear_pulses <= clear_pulses + 1;
  always #12.5 clock = ~clock;
  fmid_core fmid_core_inst (.clock(clock), .sys_rst(sys_rst), .rom_data(rom_data),
    .rom_addr(rom_addr), .ram_data(ram_data), .ram_addr(ram_addr), .gen_inputs(gen_inputs),
    .clock_out_pin(clock_out_pin), .falling_pulse_latches(falling_pulse_latches),
    .timebase_carry(timebase_carry), .shift_count_in(shift_count_in), .acc_out(acc_out),
    .carry_out(carry_out), .port_latch(port_latch), .data_port(data_port),
    .enable_reg(enable_reg), .shift_count_out(shift_count_out),
    .shift_count_load(shift_count_load), .serial_clock_output(serial_clock_output),
    .latch_clear(latch_clear));
  fmid_mem fmid_mem_inst (.rom_addr(rom_addr), .rom_data(rom_data), .ram_addr(ram_addr),
    .ram_data(ram_data));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task report_and_stop;
    $display("counts: %0d compared, %0d mismatched", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wipe(input logic [3:0] m);
    for (int i = 0; i < 1024; i++)
      fmid_mem_inst.rom[i] = 8'h44;
    for (int i = 0; i < 64; i++)
      fmid_mem_inst.ram[i] = m;
  endtask
  task put(input logic [9:0] a, input logic [63:0] p);
    for (int i = 0; i < 8; i++)
      fmid_mem_inst.rom[a + i] = p[63 - 8 * i -: 8];
  endtask
  task run;
    @(negedge clock) sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (40) @(negedge clock);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_add;
    wipe(4'h9);
    put(0, 64'h5730524444444444);
    run;
    `FMID_CHK("acc", 4'h0, acc_out)
    `FMID_CHK("carry", 1'b1, carry_out)
    $display("add test done");
  endtask
  task t_logic;
    wipe(4'h3);
    put(0, 64'h4002104044444444);
    run;
    `FMID_CHK("acc", 4'h9, acc_out)
    `FMID_CHK("carry", 1'b0, carry_out)
    $display("logic test done");
  endtask
  task t_port;
    wipe(4'h0);
    put(0, 64'h3355331151444444);
    run;
    `FMID_CHK("port", 4'h5, port_latch)
    `FMID_CHK("acc", 4'h0, acc_out)
    $display("port test done");
  endtask
  task t_skip;
    wipe(4'h8);
    put(0, 64'h2151135201544444);
    run;
    `FMID_CHK("acc", 4'h3, acc_out)
    $display("skip test done");
  endtask
  task t_io;
    int base;
    wipe(4'ha);
    put(0, 64'h333a333e33294444);
    base = clear_pulses;
    run;
    `FMID_CHK("latch clear", 1, clear_pulses - base)
    `FMID_CHK("port", 4'ha, port_latch)
    `FMID_CHK("data", 4'h0, data_port)
    `FMID_CHK("acc", 4'hd, acc_out)
    $display("io test done");
  endtask
  task t_call;
    wipe(4'h0);
    put(0, 64'h68105154c4444444);
    put(10'h010, 64'h8149444444444444);
    put(10'h081, 64'h5248444444444444);
    run;
    `FMID_CHK("acc", 4'h6, acc_out)
    $display("call test done");
  endtask
  task t_jump;
    wipe(4'h5);
    put(0, 64'hff44444444204444);
    put(8, 64'h53c9444444444444);
    put(10'h020, 64'hc85f444444444444);
    run;
    `FMID_CHK("acc", 4'h3, acc_out)
    $display("jump test done");
  endtask
  task t_swap;
    wipe(4'h1);
    put(0, 64'h5f3044514f336a18);
    put(8, 64'h333e444444444444);
    run;
    `FMID_CHK("acc", 4'h6, acc_out)
    `FMID_CHK("shifter", 4'h1, shift_count_out)
    `FMID_CHK("sclk", 1'b1, serial_clock_output)
    `FMID_CHK("enable", 4'ha, enable_reg)
    `FMID_CHK("pointer", 6'h19, ram_addr)
    `FMID_CHK("data", 4'h9, data_port)
    $display("swap test done");
  endtask
  initial
  begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial
  begin
    t_add;
    t_logic;
    t_port;
    t_skip;
    t_io;
    t_call;
    t_jump;
    t_swap;
    report_and_stop;
  end
endmodule // tb
